// File: hw/tlc_loop_counter.sv
// Behaviour
// - test passes: body token, count valid
// - test fails: finished token, count invalid
// - active from begin token until finished
// - initial value sampled at each activation; step and limit read live
// - count meaningful only while valid
// - disabled: valid low, state frozen
// - re-enabled: resume from frozen state
// - initial, step, limit drive the test
// - first and final pass markers
// - empty loop marker on immediate failure
// - loop test fixed at build time
// - begin token loads initial then tests
// - body finished token steps then tests
`timescale 1ns/1ps
module tlc_loop_counter #(
  parameter tlc_pkg::tlc_test_type loop_test = tlc_pkg::tlc_test_le
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic loop_enable,
  input wire logic loop_begin_token,
  input wire logic body_finished_token,
  input wire tlc_pkg::tlc_setup_type setup,
  output logic body_begin_token,
  output logic loop_finished_token,
  output logic count_valid,
  output logic [tlc_pkg::count_width-1:0] loop_count,
  output tlc_pkg::tlc_marker_type markers
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    tlc_idle = 2'h0,
    tlc_check = 2'h1,
    tlc_body = 2'h2
  } tlc_state_type;

  tlc_state_type state_q;
  logic [tlc_pkg::wide_width-1:0] count_q;
  logic from_init_q;
  logic pass_now;
  logic pass_next;
  logic [tlc_pkg::wide_width-1:0] next_step_d;
  logic active_q;

  // ----------------------------------------
  // loop test
  // ----------------------------------------
  // one spare bit lets a step run past the top of the range, so an le or lt test still fails there
  // next value the body would reach; used to foresee the final pass
  assign next_step_d = count_q + {1'b0, setup.step_value};

  // the current value decides this pass; the stepped value only foresees the last one
  tlc_test_unit #(
    .loop_test(loop_test)
  ) u_test_now (
    .value(count_q),
    .limit_value(setup.limit_value),
    .pass(pass_now)
  );

  tlc_test_unit #(
    .loop_test(loop_test)
  ) u_test_next (
    .value(next_step_d),
    .limit_value(setup.limit_value),
    .pass(pass_next)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // a token is taken only while enabled; tokens arriving while suspended are
  // lost, since the partner is expected to hold off while enable is low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= tlc_idle;
    end
    else if (loop_enable)
    begin
      case (state_q)
        tlc_idle:
        begin
          if (loop_begin_token)
          begin
            state_q <= tlc_check;
          end
        end
        tlc_check:
        begin
          if (pass_now)
            state_q <= tlc_body;
          else
          begin
            state_q <= tlc_idle;
          end
        end
        tlc_body:
        begin
          if (body_finished_token)
            state_q <= tlc_check;
        end
        default:
        begin
          state_q <= tlc_idle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // activity
  // ----------------------------------------
  // active from the taken begin token until the finished token leaves
  always_ff @(posedge clk)
  begin
    if (reset)
      active_q <= 1'b0;
    else if (loop_enable && !active_q && loop_begin_token)
      active_q <= 1'b1;
    else if (loop_enable && state_q == tlc_check && !pass_now)
      active_q <= 1'b0;
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_q <= tlc_pkg::wide_reset;
      from_init_q <= 1'b0;
    end
    else if (loop_enable)
    begin
      if (!active_q && loop_begin_token)
      begin
        count_q <= {1'b0, setup.initial_value};
        from_init_q <= 1'b1;
      end
      else if (state_q == tlc_body && body_finished_token)
      begin
        count_q <= next_step_d;
        from_init_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // tokens
  // ----------------------------------------
  // one check cycle yields exactly one pulse on one of the two tokens
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      body_begin_token <= 1'b0;
      loop_finished_token <= 1'b0;
    end
    else
    begin
      body_begin_token <= loop_enable && state_q == tlc_check && pass_now;
      loop_finished_token <= loop_enable && state_q == tlc_check && !pass_now;
    end
  end

  // ----------------------------------------
  // count and valid
  // ----------------------------------------
  // loop_count follows the counter even while invalid; consumers must gate it with count_valid
  // the body state itself remembers validity, so a resumed loop shows valid again
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_valid <= 1'b0;
      loop_count <= tlc_pkg::count_reset;
    end
    else
    begin
      loop_count <= count_q[tlc_pkg::count_width-1:0];
      if (!loop_enable)
        count_valid <= 1'b0;
      else if (state_q == tlc_check)
        count_valid <= pass_now;
      else
        count_valid <= (state_q == tlc_body);
    end
  end

  // ----------------------------------------
  // pass markers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      markers <= tlc_pkg::marker_reset;
    else if (loop_enable && state_q == tlc_check)
    begin
      markers.first_pass_marker <= from_init_q && pass_now;
      // the last pass is foreseen from the step that would follow, not waited for
      markers.final_pass_marker <= pass_now && !pass_next;
      markers.empty_loop_marker <= from_init_q && !pass_now;
    end
    else if (loop_enable && state_q == tlc_idle)
      markers <= tlc_pkg::marker_reset;
  end

endmodule // tlc_loop_counter

// File: hw/tlc_pkg.sv
package tlc_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned count_width = 16;
  // a wider working width keeps the step from wrapping before the test
  localparam int unsigned wide_width = count_width + 1;

  // ----------------------------------------
  // loop test encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    tlc_test_le = 2'h0,
    tlc_test_lt = 2'h1,
    tlc_test_gt = 2'h2,
    tlc_test_ge = 2'h3
  } tlc_test_type;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [count_width-1:0] count_reset = 16'h0000;
  localparam logic [wide_width-1:0] wide_reset = 17'h00000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [count_width-1:0] initial_value;
    logic [count_width-1:0] step_value;
    logic [count_width-1:0] limit_value;
  } tlc_setup_type;

  typedef struct packed {
    logic first_pass_marker;
    logic final_pass_marker;
    logic empty_loop_marker;
  } tlc_marker_type;

  localparam tlc_marker_type marker_reset = 3'h0;

endpackage

// File: hw/tlc_test_unit.sv
`timescale 1ns/1ps
module tlc_test_unit #(
  parameter tlc_pkg::tlc_test_type loop_test = tlc_pkg::tlc_test_le
) (
  input wire logic [tlc_pkg::wide_width-1:0] value,
  input wire logic [tlc_pkg::count_width-1:0] limit_value,
  output logic pass
);

  logic [tlc_pkg::wide_width-1:0] limit_wide;

  assign limit_wide = {1'b0, limit_value};

  // ----------------------------------------
  // static comparison
  // ----------------------------------------
  always_comb
  begin
    case (loop_test)
      tlc_pkg::tlc_test_le: pass = (value <= limit_wide);
      tlc_pkg::tlc_test_lt: pass = (value < limit_wide);
      tlc_pkg::tlc_test_gt: pass = (value > limit_wide);
      tlc_pkg::tlc_test_ge: pass = (value >= limit_wide);
      default: pass = 1'b0;
    endcase
  end

endmodule // tlc_test_unit

// File: verif/tlc_body_model.sv
`timescale 1ns/1ps
module tlc_body_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic loop_enable,
  input wire logic body_begin_token,
  input wire logic [3:0] body_delay,
  output logic body_finished_token
);
  // loop_count is never read here, so a count shown while invalid cannot mislead
  logic [4:0] wait_q;
  always_ff @(posedge clk)
  begin
    body_finished_token <= 1'b0;
    if (reset)
      wait_q <= 5'h00;
    else if (body_begin_token)
      wait_q <= {1'b0, body_delay} + 5'h01;
    else if (loop_enable && wait_q != 5'h00)
    begin
      wait_q <= wait_q - 5'h01;
      body_finished_token <= (wait_q == 5'h01);
    end
  end
endmodule // tlc_body_model

// File: verif/tlc_loop_counter_asserts.sv
`timescale 1ns/1ps
module tlc_loop_counter_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic loop_enable,
  input wire logic loop_begin_token,
  input wire logic body_finished_token,
  input wire tlc_pkg::tlc_setup_type setup,
  input wire logic body_begin_token,
  input wire logic loop_finished_token,
  input wire logic count_valid,
  input wire logic [tlc_pkg::count_width-1:0] loop_count,
  input wire tlc_pkg::tlc_marker_type markers
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_tokens_apart: assert property (!(body_begin_token && loop_finished_token))
    else $error("both tokens at once");
  a_token_pulse: assert property ((body_begin_token || loop_finished_token) |=> !(body_begin_token || loop_finished_token))
    else $error("token longer than a cycle");
  a_body_valid: assert property (body_begin_token |-> count_valid)
    else $error("body token without valid");
  a_done_invalid: assert property (loop_finished_token |-> !count_valid)
    else $error("finish token with valid");
  a_off_invalid: assert property (!loop_enable |=> !count_valid)
    else $error("valid while disabled");
  a_off_frozen: assert property (!loop_enable |=> $stable(loop_count) && $stable(markers))
    else $error("state moved while disabled");
  a_first_init: assert property (body_begin_token && markers.first_pass_marker |-> loop_count == setup.initial_value)
    else $error("first count not initial");
  a_answer_time: assert property (((loop_begin_token && !count_valid) || (body_finished_token && count_valid)) && loop_enable ##1 loop_enable |-> ##1 (body_begin_token || loop_finished_token))
    else $error("no token two cycles on");
  a_empty_alone: assert property (markers.empty_loop_marker |-> !count_valid && !markers.first_pass_marker)
    else $error("empty marker in a body");
endmodule // tlc_loop_counter_asserts

bind tlc_loop_counter tlc_loop_counter_asserts tlc_loop_counter_asserts_i (.clk, .reset, .loop_enable,
  .loop_begin_token, .body_finished_token, .setup, .body_begin_token, .loop_finished_token, .count_valid,
  .loop_count, .markers);

// File: verif/tlc_loop_counter_bench.sv
`timescale 1ns/1ps
module tlc_loop_counter_bench;
  logic clk, reset, loop_enable, loop_begin_token, body_finished_token, body_begin_token, loop_finished_token;
  logic count_valid;
  logic [3:0] body_delay;
  logic [15:0] loop_count;
  tlc_pkg::tlc_setup_type setup;
  tlc_pkg::tlc_marker_type markers;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  tlc_loop_counter tlc_loop_counter_i (.clk, .reset, .loop_enable, .loop_begin_token, .body_finished_token,
    .setup, .body_begin_token, .loop_finished_token, .count_valid, .loop_count, .markers);
  tlc_body_model tlc_body_model_i (.clk, .reset, .loop_enable, .body_begin_token, .body_delay,
    .body_finished_token);
  always #12.5 clk = ~clk;
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_loop(input logic [15:0] ini, stp, lim, input int n_exp, input logic [3:0] dly, input bit stall);
    int n;
    logic [15:0] v;
    n = 0;
    @(posedge clk);
    setup <= {ini, stp, lim};
    body_delay <= dly;
    loop_begin_token <= 1'b1;
    @(posedge clk);
    loop_begin_token <= 1'b0;
    forever
    begin
      @(negedge clk);
      v = ini + stp * n;
      if (body_begin_token === 1'b1)
      begin
        check(loop_count, v);
        check(markers, {n == 0, n == n_exp - 1, 1'b0});
        if (stall && n == 1)
        begin
          @(posedge clk);
          loop_enable <= 1'b0;
          @(posedge clk);
          repeat (4) @(negedge clk) check({count_valid, loop_count}, {1'b0, v});
          @(posedge clk);
          loop_enable <= 1'b1;
          @(posedge clk);
          @(negedge clk);
          check({count_valid, loop_count}, {1'b1, v});
        end
        n++;
      end
      if (loop_finished_token === 1'b1)
        break;
    end
    check(n, n_exp);
    check({count_valid, markers.empty_loop_marker}, n_exp == 0);
  endtask
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    loop_enable = 1'b1;
    loop_begin_token = 1'b0;
    setup = '0;
    body_delay = 4'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({body_begin_token, loop_finished_token, count_valid, markers}, 17'h00000);
    run_loop(16'h0003, 16'h0002, 16'h0009, 4, 4'h0, 1'b0);
    run_loop(16'h0005, 16'h0001, 16'h0004, 0, 4'h2, 1'b0);
    run_loop(16'h0000, 16'h0004, 16'h000c, 4, 4'h8, 1'b1);
    run_loop(16'hfffe, 16'h0001, 16'hffff, 2, 4'h1, 1'b0);
    run_loop(16'h0007, 16'h0003, 16'h0007, 1, 4'h0, 1'b0);
    conclude();
  end
endmodule // tlc_loop_counter_bench
